// ---- shared/sec_pkg.sv ----
// Constants, encodings and state types for the serial memory command core
package sec_pkg;
  localparam logic [7:0] OP_ARM = 8'h06;
  localparam logic [7:0] OP_DISARM = 8'h04;
  localparam logic [7:0] OP_SRD = 8'h05;
  localparam logic [7:0] OP_SWR = 8'h01;
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_WR = 8'h02;
  // Bit counts after the last rising edge of each frame phase, and the count a data stream wraps back to
  localparam logic [5:0] CNT_OPC = 6'h08;
  localparam logic [5:0] CNT_SWR = 6'h10;
  localparam logic [5:0] CNT_ADDR = 6'h18;
  localparam logic [5:0] CNT_BYTE = 6'h20;
  localparam logic [5:0] CNT_WRAP = 6'h19;
  // Status byte fields
  localparam int ST_LOCK = 7;
  localparam int ST_RSV_HI = 6;
  localparam int ST_RSV_LO = 4;
  localparam int ST_BPH = 3;
  localparam int ST_BPL = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  // Pin sync reset image: vdd_low, wp_n, hold_n, si, sck, cs_n
  localparam logic [5:0] PIN_RST = 6'h19;
  // Programming time
  localparam int unsigned T_PR_US = 5000;
  localparam int unsigned SYS_CLK_MHZ = 40;
  localparam int unsigned PROG_CYC = T_PR_US * SYS_CLK_MHZ;
  localparam int PROG_W = 18;
  // Storage geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 32;
  localparam int ECC_W = 6;
  localparam int CW_W = 38;
  localparam int GRP_IDX_W = 13;
  localparam int MEM_GROUPS = 8192;
  localparam int PAGE_BYTES = 64;
  localparam logic [3:0] GRP_LAST = 4'hF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    F_OPC = 3'b000,
    F_ARM = 3'b001,
    F_DIS = 3'b010,
    F_SRD = 3'b011,
    F_SWR = 3'b100,
    F_RD = 3'b101,
    F_WR = 3'b110,
    F_IGN = 3'b111
  } sec_frame_e;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_COMMIT = 2'b01,
    P_WAIT = 2'b10
  } sec_prog_e;
endpackage : sec_pkg

// ---- shared/sec_mem_if.sv ----
// Word access path between the command core and the protected storage array
`timescale 1ns/1ps
`default_nettype none
interface sec_mem_if;
  logic [12:0] rd_idx;
  logic [31:0] rd_word;
  logic wr_en;
  logic [12:0] wr_idx;
  logic [31:0] wr_word;
  modport core (output rd_idx, output wr_en, output wr_idx, output wr_word, input rd_word);
  modport store (input rd_idx, input wr_en, input wr_idx, input wr_word, output rd_word);
endinterface : sec_mem_if
`default_nettype wire

// ---- verilog/sec_mem.sv ----
// Storage array of four-byte groups, each kept with six check bits
`timescale 1ns/1ps
`default_nettype none
module sec_mem
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  sec_mem_if.store mif // Word read and write path
);
  localparam int CW = sec_pkg::CW_W;

  function automatic logic [CW:1] ham_enc(input logic [31:0] d);
    logic [CW:1] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= CW; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        c[p] = d[j];
        j++;
      end
    end
    for (int p = 1; p <= CW; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        for (int k = 0; k < sec_pkg::ECC_W; k++)
        begin
          if (p[k])
            c[1 << k] = c[1 << k] ^ c[p];
        end
      end
    end
    return c;
  endfunction : ham_enc

  function automatic logic [31:0] ham_dec(input logic [CW:1] cw);
    logic [CW:1] c;
    logic [31:0] d;
    int syn;
    int j;
    c = cw;
    d = '0;
    syn = 0;
    j = 0;
    for (int p = 1; p <= CW; p++)
    begin
      if (c[p])
        syn = syn ^ p;
    end
    // Double errors may alias to a valid position and flip a third bit; only syndromes above 38 pass through uncorrected
    if (syn >= 1 && syn <= CW)
      c[syn] = ~c[syn];
    for (int p = 1; p <= CW; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        d[j] = c[p];
        j++;
      end
    end
    return d;
  endfunction : ham_dec

  localparam logic [CW:1] ERASED_CW = ham_enc({4{sec_pkg::ERASED_BYTE}});

  logic [CW:1] arr_r [sec_pkg::MEM_GROUPS];

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < sec_pkg::MEM_GROUPS; i++)
        arr_r[i] <= ERASED_CW;
    end
    else if (mif.wr_en)
      arr_r[mif.wr_idx] <= ham_enc(mif.wr_word);
  end

  assign mif.rd_word = ham_dec(arr_r[mif.rd_idx]);
endmodule : sec_mem
`default_nettype wire

// ---- verilog/sec_core.sv ----
// Serial memory command core: pin sampling, frame decode, status and programming
// Contract
// - Chip select high: deselected, serial output floating.
// - Deselected and not programming means standby; select low makes active.
// - Opcode, address and write data are captured on shift clock rising edges.
// - Serial output changes only on shift clock falling edges.
// - Pause pin floats output, ignores input and clock, keeps transfer state.
// - Memory starts erased to FFh; nonvolatile status bits start at zero.
// - Six check bits per four-byte group; single-bit errors corrected on read.
// - Any byte write reprograms its whole four-byte group with new check bits.
// - Each instruction is one 8-bit opcode, MSB first, after select falls.
// - Unknown opcode deselects the device until select is cycled.
// - Opcodes 06 arm, 04 disarm, 05 status read on clocks 9 to 16.
// - Opcodes 01 status write, 03 memory read, 02 memory write.
// - Read and write carry 16-bit address high first; top bit ignored.
// - Status read repeats the status byte while clocks continue.
// - Memory read advances address and streams a byte every further eight clocks.
// - Lock bit set with protect pin low blocks status writes.
// - Guard bits 3 and 2 select the area shielded from memory writes.
// - Write enable latch set only by arm; clear latch rejects writes.
// - Latch cleared on power-up, brown-out, disarm and end of programming.
// - Status bit 0 is one exactly while a programming cycle runs.
// - Arm takes effect only when select rises right after clock eight.
// - Select rising after any other clock count discards the arm.
// - Page write increments only the low six address bits, wrapping.
// - Status bits 6 to 4 read zero and ignore writes.
// - Memory read opcodes are ignored during programming.
`timescale 1ns/1ps
`default_nettype none
module sec_core
#(
  parameter int unsigned PROG_CYCLES = sec_pkg::PROG_CYC // Programming cycle length
)
(
  input wire logic i_sys_clk, // System clock, 40 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_cs_n, // Chip select pin, active low
  input wire logic i_sck, // Shift clock pin
  input wire logic i_si, // Serial data input pin
  input wire logic i_hold_n, // Pause pin, active low
  input wire logic i_wp_n, // Write protect pin, active low
  input wire logic i_vdd_low, // Supply brown-out indication, active high
  output logic o_so, // Serial data output
  output logic o_so_oe_n, // Serial output enable, low while driving
  output logic o_standby // High while in standby
);
  localparam int PW = sec_pkg::PROG_W;
  localparam logic [PW-1:0] TMR_LOAD = PW'(PROG_CYCLES - 1);
  localparam logic [PW-1:0] TMR_ONE = PW'(1);

  logic [5:0] pins_raw;
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic sck_d_r;
  logic cs_d_r;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;
  logic vdd_low_s;

  sec_pkg::sec_frame_e fst_r;
  sec_pkg::sec_frame_e dec_st;
  logic [5:0] cnt_r;
  logic [7:0] sh_r;
  logic [14:0] addr_r;
  logic [7:0] out_r;
  logic oe_r;
  logic [7:0] swr_pend_r;
  logic [7:0] wbuf_r [sec_pkg::PAGE_BYTES];
  logic [63:0] wvld_r;

  sec_pkg::sec_prog_e pst_r;
  logic [3:0] grp_r;
  logic [PW-1:0] tmr_r;
  logic pkind_r;
  logic lock_r;
  logic [1:0] bp_r;
  logic wel_r;
  logic wel_nxt;
  logic standby_r;

  logic held;
  logic sel;
  logic rise;
  logic fall;
  logic cs_rise;
  logic busy;
  logic hw_lock;
  logic [7:0] byte_in;
  logic [14:0] addr_in;
  logic [5:0] cnt_inc;
  logic guard_hit;
  logic opc_done;
  logic addr_phase;
  logic wr_guarded;
  logic wr_byte;
  logic swr_byte;
  logic ld_st;
  logic ld_rd;
  logic start_wr;
  logic start_sw;
  logic arm_done;
  logic dis_done;
  logic prog_done;
  logic [7:0] rd_byte;
  wire [7:0] status;
  wire [31:0] merged;
  wire [3:0] grp_vld;

  sec_mem_if mif ();

  // Pin sampling
  assign pins_raw = {i_vdd_low, i_wp_n, i_hold_n, i_si, i_sck, i_cs_n};

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_r <= sec_pkg::PIN_RST;
      sync_r <= sec_pkg::PIN_RST;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      meta_r <= pins_raw;
      sync_r <= meta_r;
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end

  assign cs_n_s = sync_r[0];
  assign sck_s = sync_r[1];
  assign si_s = sync_r[2];
  assign hold_n_s = sync_r[3];
  assign wp_n_s = sync_r[4];
  assign vdd_low_s = sync_r[5];

  // Edges seen while paused are dropped; the clock history still tracks,
  // so release with the clock high gives no false edge
  assign held = ~hold_n_s;
  assign sel = ~cs_n_s;
  assign rise = sel & ~held & sck_s & ~sck_d_r;
  assign fall = sel & ~held & ~sck_s & sck_d_r;
  assign cs_rise = cs_n_s & ~cs_d_r;

  // Frame decode
  assign busy = (pst_r != sec_pkg::P_IDLE);
  assign hw_lock = lock_r & ~wp_n_s;
  assign byte_in = {sh_r[6:0], si_s};
  assign addr_in = {addr_r[13:0], si_s};
  assign cnt_inc = (cnt_r == sec_pkg::CNT_BYTE) ? sec_pkg::CNT_WRAP : cnt_r + 6'h01;
  assign guard_hit = (bp_r == sec_pkg::BP_ALL)
                   | ((bp_r == sec_pkg::BP_HALF) & addr_in[14])
                   | ((bp_r == sec_pkg::BP_QUARTER) & (&addr_in[14:13]));

  assign dec_st = (byte_in == sec_pkg::OP_ARM) ? sec_pkg::F_ARM :
                  (byte_in == sec_pkg::OP_DISARM) ? sec_pkg::F_DIS :
                  (byte_in == sec_pkg::OP_SRD) ? sec_pkg::F_SRD :
                  (byte_in == sec_pkg::OP_SWR) ?
                    ((wel_r & ~busy & ~hw_lock) ? sec_pkg::F_SWR : sec_pkg::F_IGN) :
                  (byte_in == sec_pkg::OP_RD) ?
                    (busy ? sec_pkg::F_IGN : sec_pkg::F_RD) :
                  (byte_in == sec_pkg::OP_WR) ?
                    ((wel_r & ~busy) ? sec_pkg::F_WR : sec_pkg::F_IGN) :
                  sec_pkg::F_IGN;

  assign opc_done = (fst_r == sec_pkg::F_OPC) & (cnt_inc == sec_pkg::CNT_OPC);
  assign addr_phase = ((fst_r == sec_pkg::F_RD) | (fst_r == sec_pkg::F_WR))
                    & (cnt_inc <= sec_pkg::CNT_ADDR);
  assign wr_guarded = (fst_r == sec_pkg::F_WR) & (cnt_inc == sec_pkg::CNT_ADDR) & guard_hit;
  assign wr_byte = (fst_r == sec_pkg::F_WR) & (cnt_inc == sec_pkg::CNT_BYTE);
  assign swr_byte = (fst_r == sec_pkg::F_SWR) & (cnt_inc == sec_pkg::CNT_SWR);
  assign ld_st = (fst_r == sec_pkg::F_SRD) & (cnt_r >= sec_pkg::CNT_OPC) & (cnt_r[2:0] == 3'h0);
  assign ld_rd = (fst_r == sec_pkg::F_RD) & (cnt_r >= sec_pkg::CNT_ADDR) & (cnt_r[2:0] == 3'h0);
  assign rd_byte = mif.rd_word[{addr_r[1:0], 3'b000} +: 8];

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      fst_r <= sec_pkg::F_OPC;
      cnt_r <= '0;
      sh_r <= '0;
      addr_r <= '0;
      out_r <= '0;
      oe_r <= 1'b0;
      swr_pend_r <= '0;
      wvld_r <= '0;
      for (int i = 0; i < sec_pkg::PAGE_BYTES; i++)
        wbuf_r[i] <= '0;
    end
    else if (cs_n_s)
    begin
      // A new low period always starts from the opcode
      fst_r <= sec_pkg::F_OPC;
      cnt_r <= '0;
      oe_r <= 1'b0;
    end
    else if (rise)
    begin
      cnt_r <= cnt_inc;
      sh_r <= byte_in;
      if (opc_done)
        fst_r <= dec_st;
      if (opc_done && dec_st == sec_pkg::F_WR)
        wvld_r <= '0;
      if (addr_phase)
        addr_r <= addr_in;
      if (wr_guarded)
        fst_r <= sec_pkg::F_IGN;
      if (wr_byte)
      begin
        wbuf_r[addr_r[5:0]] <= byte_in;
        wvld_r[addr_r[5:0]] <= 1'b1;
        addr_r[5:0] <= addr_r[5:0] + 6'h01;
      end
      if (swr_byte)
        swr_pend_r <= byte_in;
    end
    else if (fall)
    begin
      if (ld_st)
      begin
        out_r <= status;
        oe_r <= 1'b1;
      end
      else if (ld_rd)
      begin
        out_r <= rd_byte;
        addr_r <= addr_r + 15'h0001;
        oe_r <= 1'b1;
      end
      else
        out_r <= {out_r[6:0], 1'b0};
    end
  end

  // Output floats unless selected, not paused and in a data-out phase;
  // a select that rises during a pause ends the frame
  assign o_so = out_r[7];
  assign o_so_oe_n = ~(oe_r & sel & ~held);

  // Frame completion on select rising edge
  assign start_wr = cs_rise & (fst_r == sec_pkg::F_WR) & (cnt_r == sec_pkg::CNT_BYTE);
  assign start_sw = cs_rise & (fst_r == sec_pkg::F_SWR) & (cnt_r == sec_pkg::CNT_SWR);
  assign arm_done = cs_rise & (fst_r == sec_pkg::F_ARM) & (cnt_r == sec_pkg::CNT_OPC);
  assign dis_done = cs_rise & (fst_r == sec_pkg::F_DIS) & (cnt_r == sec_pkg::CNT_OPC);
  assign prog_done = (pst_r == sec_pkg::P_WAIT) & (tmr_r == '0);

  // Group merge: unwritten bytes keep their corrected old value
  assign grp_vld = wvld_r[{grp_r, 2'b00} +: 4];
  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
      localparam logic [1:0] LANE = 2'(b);
      assign merged[8*b +: 8] = wvld_r[{grp_r, LANE}] ? wbuf_r[{grp_r, LANE}]
                                                      : mif.rd_word[8*b +: 8];
    end
  endgenerate

  assign mif.rd_idx = busy ? {addr_r[14:6], grp_r} : addr_r[14:2];
  assign mif.wr_idx = {addr_r[14:6], grp_r};
  assign mif.wr_word = merged;
  assign mif.wr_en = (pst_r == sec_pkg::P_COMMIT) & (|grp_vld);

  sec_mem u_mem
  (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .mif(mif)
  );

  // Programming: commit groups one per cycle, then hold busy for the full time
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pst_r <= sec_pkg::P_IDLE;
      grp_r <= '0;
      tmr_r <= '0;
      pkind_r <= 1'b0;
      lock_r <= 1'b0;
      bp_r <= sec_pkg::BP_NONE;
    end
    else
    begin
      unique case (pst_r)
        sec_pkg::P_IDLE:
        begin
          if (start_wr)
          begin
            pst_r <= sec_pkg::P_COMMIT;
            grp_r <= '0;
            pkind_r <= 1'b0;
          end
          else if (start_sw)
          begin
            pst_r <= sec_pkg::P_WAIT;
            tmr_r <= TMR_LOAD;
            pkind_r <= 1'b1;
          end
        end
        sec_pkg::P_COMMIT:
        begin
          grp_r <= grp_r + 4'h1;
          if (grp_r == sec_pkg::GRP_LAST)
          begin
            pst_r <= sec_pkg::P_WAIT;
            tmr_r <= TMR_LOAD;
          end
        end
        sec_pkg::P_WAIT:
        begin
          if (tmr_r == '0)
          begin
            pst_r <= sec_pkg::P_IDLE;
            // New nonvolatile bits appear only once the cycle is over
            if (pkind_r)
            begin
              lock_r <= swr_pend_r[sec_pkg::ST_LOCK];
              bp_r <= swr_pend_r[sec_pkg::ST_BPH:sec_pkg::ST_BPL];
            end
          end
          else
            tmr_r <= tmr_r - TMR_ONE;
        end
        default:
          pst_r <= sec_pkg::P_IDLE;
      endcase
    end
  end

  // Arm beats a same-cycle end-of-programming clear; brown-out beats both
  assign wel_nxt = vdd_low_s ? 1'b0 :
                   arm_done ? 1'b1 :
                   (dis_done | prog_done) ? 1'b0 :
                   wel_r;

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wel_r <= 1'b0;
      standby_r <= 1'b1;
    end
    else
    begin
      wel_r <= wel_nxt;
      standby_r <= cs_n_s & ~busy;
    end
  end

  assign status[sec_pkg::ST_LOCK] = lock_r;
  assign status[sec_pkg::ST_RSV_HI:sec_pkg::ST_RSV_LO] = 3'h0;
  assign status[sec_pkg::ST_BPH:sec_pkg::ST_BPL] = bp_r;
  assign status[sec_pkg::ST_WEL] = wel_r;
  assign status[sec_pkg::ST_BUSY] = busy;
  assign o_standby = standby_r;
endmodule : sec_core
`default_nettype wire

// ---- verif/sec_core_properties.sv ----
// Port-level checker for the serial memory command core
`timescale 1ns/1ps
`default_nettype none
module sec_core_properties
#(
  parameter int unsigned PROG_CYCLES = sec_pkg::PROG_CYC // Programming cycle length
)
(
  input wire logic i_sys_clk, // System clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_cs_n, // Chip select pin
  input wire logic i_sck, // Shift clock pin
  input wire logic i_si, // Serial data in
  input wire logic i_hold_n, // Pause pin
  input wire logic i_wp_n, // Write protect pin
  input wire logic i_vdd_low, // Brown-out
  input wire logic o_so, // Serial data out
  input wire logic o_so_oe_n, // Output enable, low driving
  input wire logic o_standby // Standby flag
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // Pin-level shadow of the frame; runs ahead of the synchroniser on purpose
  logic sck_r;
  logic [5:0] cnt_r;
  logic [7:0] op_r;
  wire logic rise = i_sck && !sck_r;
  wire logic [5:0] cnt_nxt = i_cs_n ? 6'h00 : cnt_r + {5'h00, rise && cnt_r != 6'h3F};
  wire logic [7:0] op_nxt = (rise && !i_cs_n && cnt_r < 6'h08) ? {op_r[6:0], i_si} : op_r;
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      {sck_r, cnt_r, op_r} <= 15'h0000;
    else
      {sck_r, cnt_r, op_r} <= {i_sck, cnt_nxt, op_nxt};
  end
  sequence desel_held;
    i_cs_n [*4];
  endsequence
  sequence sel_held;
    $fell(i_cs_n) ##1 !i_cs_n [*4];
  endsequence
  a_desel_float: assert property (desel_held |-> o_so_oe_n)
    else $error("output driven while deselected");
  a_select_active: assert property (sel_held |-> !o_standby)
    else $error("standby while selected");
  a_standby_float: assert property (o_standby |-> o_so_oe_n)
    else $error("output driven in standby");
  a_pause_float: assert property (!i_hold_n [*4] |-> o_so_oe_n)
    else $error("output driven during pause");
  a_so_fall_only: assert property (!o_so_oe_n && $changed(o_so) |-> !i_sck)
    else $error("output changed while clock high");
  a_so_steady_high: assert property (i_sck && $past(i_sck) && !o_so_oe_n |-> $stable(o_so))
    else $error("output moved in clock high phase");
  a_drive_on_low: assert property ($fell(o_so_oe_n) |-> !i_sck)
    else $error("drive began with clock high");
  a_drive_late: assert property ($fell(o_so_oe_n) |-> cnt_r >= 6'h08)
    else $error("drive began before eight clocks");
  a_no_output_op: assert property (cnt_r >= 6'h08 && op_r != sec_pkg::OP_SRD
    && op_r != sec_pkg::OP_RD |-> o_so_oe_n)
    else $error("output driven for opcode without data out");
endmodule : sec_core_properties
bind sec_core sec_core_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .i_hold_n(i_hold_n),
  .i_wp_n(i_wp_n), .i_vdd_low(i_vdd_low), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
  .o_standby(o_standby));
`default_nettype wire

// ---- verif/sec_host_model.sv ----
// Host shift-clock controller model for the serial pins
`timescale 1ns/1ps
`default_nettype none
module sec_host_model
(
  input wire logic i_sys_clk, // System clock, drive reference
  input wire logic i_so, // Device serial out
  input wire logic i_so_oe_n, // Device output enable, low driving
  output logic o_cs_n, // Chip select
  output logic o_sck, // Shift clock, still between frames
  output logic o_si // Serial data to device
);
  int half = 4;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : idle
  // Reply bit sampled just before each rise, after the device settled it
  task automatic xfer(input int n, input logic [63:0] tx, input bit keep,
    output logic [63:0] rx, output bit drv);
    rx = '0;
    drv = 1'b0;
    if (o_cs_n)
    begin
      o_cs_n = ~o_cs_n;
      idle(half);
    end
    for (int k = n - 1; k >= 0; k--)
    begin
      o_si = tx[k];
      idle(half);
      // A floating line reads as the inverse of its last level, so no stale bit passes
      rx = {rx[62:0], (i_so_oe_n === 1'b0) ? i_so : ~i_so};
      if (i_so_oe_n === 1'b0)
        drv = 1'b1;
      o_sck = ~o_sck;
      idle(half);
      o_sck = ~o_sck;
    end
    if (!keep)
    begin
      idle(half);
      o_cs_n = ~o_cs_n;
      o_si = ~o_si;
      idle(half);
    end
  endtask : xfer
  // Select stays low across the pause
  task automatic pulse(input int n);
    repeat (n)
    begin
      o_si = ~o_si;
      idle(half);
      o_sck = ~o_sck;
      idle(half);
      o_sck = ~o_sck;
    end
  endtask : pulse
endmodule : sec_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the serial memory command core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Short programming time keeps the run brief
  localparam int unsigned PROG = 400;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_hold_n = 1'b1;
  logic i_wp_n = 1'b1;
  logic i_vdd_low = 1'b0;
  wire logic cs_n, sck, si, so, so_oe_n, standby;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 91353;
  logic [7:0] mem_m [int];
  logic [63:0] rx;
  bit drv;
  logic [7:0] st, d0, d1;
  logic [14:0] a;
  always #12.5 i_sys_clk = ~i_sys_clk;
  sec_core #(.PROG_CYCLES(PROG)) dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n),
    .i_vdd_low(i_vdd_low), .o_so(so), .o_so_oe_n(so_oe_n), .o_standby(standby));
  sec_host_model host (.i_sys_clk(i_sys_clk), .i_so(so), .i_so_oe_n(so_oe_n),
    .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  function automatic logic [7:0] exp_mem(input logic [14:0] ad);
    return mem_m.exists(int'(ad)) ? mem_m[int'(ad)] : 8'hFF;
  endfunction : exp_mem
  task automatic cmd(input int n, input logic [63:0] tx);
    host.xfer(n, tx, 1'b0, rx, drv);
  endtask : cmd
  task automatic rdst();
    host.half = 4 + ($random(seed) & 3);
    cmd(16, {48'h0, sec_pkg::OP_SRD, 8'h00});
    st = rx[7:0];
  endtask : rdst
  task automatic poll();
    for (int i = 0; i < 80; i++)
    begin
      rdst();
      if (st[0] === 1'b0)
        return;
    end
    mismatches++;
    results();
  endtask : poll
  // Three bytes streamed from one address, wrapping at the top
  task automatic rd_chk(input logic [14:0] ad);
    cmd(48, {16'h0, sec_pkg::OP_RD, 1'b0, ad, 24'h0});
    chk_byte(rx[23:16], exp_mem(ad));
    chk_byte(rx[15:8], exp_mem(15'(ad + 15'h1)));
    chk_byte(rx[7:0], exp_mem(15'(ad + 15'h2)));
  endtask : rd_chk
  task automatic arm();
    cmd(8, 64'(sec_pkg::OP_ARM));
  endtask : arm
  initial
  begin
    repeat (6) @(negedge i_sys_clk);
    chk_bit(standby, 1'b1);
    chk_bit(so_oe_n, 1'b1);
    i_resetn = 1'b1;
    // Lock bit is clear until the status write, so the protect pin is free here
    i_wp_n = 1'($random(seed));
    host.idle(4);
    rdst();
    chk_byte(st, 8'h00);
    cmd(7, 64'h03);
    rdst();
    chk_byte(st, 8'h00);
    cmd(9, 64'h0C);
    rdst();
    chk_byte(st, 8'h00);
    arm();
    rdst();
    chk_byte(st, 8'h02);
    cmd(8, 64'(sec_pkg::OP_DISARM));
    rdst();
    chk_byte(st, 8'h00);
    arm();
    i_vdd_low = ~i_vdd_low;
    host.idle(4);
    i_vdd_low = ~i_vdd_low;
    host.idle(4);
    rdst();
    chk_byte(st, 8'h00);
    cmd(32, {32'h0, sec_pkg::OP_WR, 16'h7FFF, 8'h55});
    rdst();
    chk_byte(st, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      d0 = 8'($random(seed));
      if (d0 inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06})
        d0 = 8'hA0;
      host.xfer(24, {40'h0, d0, sec_pkg::OP_SRD, 8'h00}, 1'b0, rx, drv);
      chk_bit(drv, 1'b0);
    end
    arm();
    host.xfer(12, {52'h0, sec_pkg::OP_SRD, 4'h0}, 1'b1, rx, drv);
    chk_byte({4'h0, rx[3:0]}, 8'h00);
    // Let the last clock fall pass the synchroniser before pausing
    host.idle(4);
    i_hold_n = ~i_hold_n;
    host.idle(4);
    host.pulse(3);
    host.idle(4);
    i_hold_n = ~i_hold_n;
    host.idle(4);
    host.xfer(12, 64'hFFF, 1'b0, rx, drv);
    chk_byte(rx[11:4], 8'h20);
    chk_byte(rx[7:0], 8'h02);
    a = 15'($random(seed));
    a[5:0] = 6'h3F;
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    cmd(40, {24'h0, sec_pkg::OP_WR, 1'b1, a, d0, d1});
    mem_m[int'(a)] = d0;
    mem_m[int'({a[14:6], 6'h00})] = d1;
    chk_bit(standby, 1'b0);
    rdst();
    chk_byte(st, 8'h03);
    cmd(32, {32'h0, sec_pkg::OP_RD, 1'b0, a, 8'h00});
    chk_bit(drv, 1'b0);
    poll();
    chk_byte(st, 8'h00);
    chk_bit(standby, 1'b1);
    rd_chk(a);
    rd_chk({a[14:6], 6'h00});
    rd_chk({a[14:2], 2'h1});
    rd_chk(15'h7FFE);
    arm();
    cmd(16, {48'h0, sec_pkg::OP_SWR, 8'hFC});
    poll();
    chk_byte(st, 8'h8C);
    arm();
    cmd(32, {32'h0, sec_pkg::OP_WR, 1'b0, a, 8'h11});
    poll();
    rd_chk(a);
    i_wp_n = 1'b0;
    arm();
    cmd(16, {48'h0, sec_pkg::OP_SWR, 8'h00});
    poll();
    chk_byte(st & 8'hFD, 8'h8C);
    i_wp_n = 1'b1;
    arm();
    cmd(16, {48'h0, sec_pkg::OP_SWR, 8'h00});
    poll();
    chk_byte(st, 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
